// ===== slcr_host_model.sv
module slcr_host_model (
    output logic chip_enable_in,
    output logic serial_bit_clock_in,
    output logic serial_bit_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // Link parked: enable low, clock still, data low
    initial begin
        chip_enable_in = 1'b0;
        serial_bit_clock_in = 1'b0;
        serial_bit_in = 1'b0;
    end

    // Data moves while the clock is low, so it is settled at the rise
    task automatic put_bit(input logic b);
        serial_bit_clock_in = 1'b0;
        serial_bit_in = b;
        #80;
        serial_bit_clock_in = 1'b1;
        #80;
    endtask

    // Address with enable low, then n frame bits inside the window
    task automatic send(input logic [7:0] a, input logic [47:0] f,
                        input int n, input logic idle);
        serial_bit_clock_in = idle;
        #160;
        for (int i = 0; i < 8; i++) put_bit(a[i]);
        serial_bit_clock_in = idle;
        #160;
        chip_enable_in = 1'b1;
        #160;
        for (int i = 0; i < n; i++) put_bit(f[i % 48]);
        serial_bit_clock_in = idle;
        #160;
        chip_enable_in = 1'b0;
        #160;
        // Held bit has expired: invert it so stale data never looks valid
        serial_bit_in = ~serial_bit_in;
    endtask
endmodule // slcr_host_model

// ===== slcr_pkg.sv
package slcr_pkg;
    // Frame geometry
    localparam int ADDR_BITS = 8;
    localparam int FRAME_BITS = 48;
    localparam int SEG_COUNT = 28;
    localparam int DUTY_BITS = 6;
    localparam logic [5:0] FRAME_BITS_CNT = 6'h30;
    localparam logic [5:0] CNT_MAX = 6'h3F;
    // Device address; the value is arbitrary
    localparam logic [7:0] DEV_ADDR_DEFAULT = 8'h5A;
    // Field positions inside a received frame (first bit lands at 0)
    localparam int F_DT0 = 28;
    localparam int F_DT1 = 29;
    localparam int F_FC_LSB = 30;
    localparam int F_DN = 34;
    localparam int F_EXF = 35;
    localparam int F_OC = 36;
    localparam int F_SC = 37;
    localparam int F_BU = 38;
    localparam int F_P_LSB = 39;
    localparam int F_W1_LSB = 0;
    localparam int F_W2_LSB = 6;
    localparam int F_W3_LSB = 12;
    localparam int F_KIND_LSB = 46;
    localparam logic [1:0] KIND_DISPLAY = 2'h0;
    localparam logic [1:0] KIND_PULSE = 2'h1;
    // APB map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_GOOD = 8'h08;
    localparam logic [7:0] REG_BAD = 8'h0C;
    localparam logic CTRL_RESET = 1'b1;
    localparam int CNT_W = 16;

    typedef enum logic {RX_ADDR, RX_DATA} slcr_rx_state_t;
    typedef enum logic [1:0] {
        DRV_QUARTER, DRV_THIRD, DRV_HALF, DRV_STATIC
    } slcr_drive_t;

    typedef struct packed {
        logic [SEG_COUNT-1:0] segment_data_bits;
        logic drive_type_bit0;
        logic drive_type_bit1;
        logic [3:0] frame_rate_sel;
        logic last_segment_enable;
        logic ext_clock_rate_sel;
        logic clock_source_sel;
        logic all_segments_blank;
        logic low_power_sel;
        logic [2:0] port_pin_function_sel;
        logic [DUTY_BITS-1:0] pulse_duty_ch1;
        logic [DUTY_BITS-1:0] pulse_duty_ch2;
        logic [DUTY_BITS-1:0] pulse_duty_ch3;
    } slcr_cfg_t;

    typedef struct packed {
        logic [23:0] segment_outputs;
        logic common_out_1;
        logic common2_or_segment;
        logic common3_or_segment;
        logic common4_or_segment;
        logic last_segment_out;
    } slcr_pins_t;
endpackage

// ===== slcr_receiver.sv
module slcr_receiver #(
    parameter logic [7:0] DEV_ADDR = slcr_pkg::DEV_ADDR_DEFAULT,
    parameter int HALF_FRAME_CYCLES = 2500
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chip_enable_in,
    input wire logic serial_bit_clock_in,
    input wire logic serial_bit_in,
    input wire logic display_off_n,
    output slcr_pkg::slcr_cfg_t cfg,
    output slcr_pkg::slcr_pins_t pins,
    output logic ext_rate_effective,
    output logic osc_running
);
    import slcr_pkg::*;

    logic [3:0] sync1, sync2, sync3;
    logic ce_s, ce_d, cl_s, cl_d, di_s, disp_on;
    logic ce_rise, ce_fall, cl_rise;
    slcr_rx_state_t state, next_state;
    logic [ADDR_BITS-1:0] addr_sr, next_addr_sr;
    logic [FRAME_BITS-1:0] sr, next_sr;
    logic [5:0] cnt, next_cnt;
    logic addr_ok, next_addr_ok;
    slcr_cfg_t cfg_q, next_cfg;
    logic [CNT_W-1:0] good_cnt, next_good, bad_cnt, next_bad;
    logic rx_enable, next_rx_enable;
    logic [31:0] next_prdata;
    logic [19:0] tmr, next_tmr, half_limit;
    logic phase, next_phase, half_tick;
    logic [1:0] slot, next_slot, duty_last;
    slcr_drive_t mode;
    logic [SEG_COUNT-1:0] seg_lvl;
    logic [3:0] port_mask;
    slcr_pins_t next_pins;

    // Two-flop synchronisers plus one delay stage for edge finding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
        end else if (clk_en) begin
            sync1 <= {chip_enable_in, serial_bit_clock_in, serial_bit_in,
                      display_off_n};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Only the second and third stages are looked at
    assign ce_s = sync2[3];
    assign ce_d = sync3[3];
    assign cl_s = sync2[2];
    assign cl_d = sync3[2];
    assign di_s = sync2[1];
    assign disp_on = sync2[0];
    assign ce_rise = ce_s & ~ce_d;
    assign ce_fall = ~ce_s & ce_d;
    assign cl_rise = cl_s & ~cl_d;

    // Receiver: works on edges only, so the clock idle level is free
    always_comb begin
        next_state = state;
        next_addr_sr = addr_sr;
        next_sr = sr;
        next_cnt = cnt;
        next_addr_ok = addr_ok;
        next_cfg = cfg_q;
        next_good = good_cnt;
        next_bad = bad_cnt;
        case (state)
            RX_ADDR: begin
                if (cl_rise) begin
                    next_addr_sr = {di_s, addr_sr[ADDR_BITS-1:1]};
                end
                if (ce_rise) begin
                    next_state = RX_DATA;
                    next_addr_ok = (next_addr_sr == DEV_ADDR);
                    next_cnt = 6'h00;
                end
            end
            RX_DATA: begin
                if (cl_rise) begin
                    next_sr = {di_s, sr[FRAME_BITS-1:1]};
                    if (cnt != CNT_MAX) begin
                        next_cnt = cnt + 6'h01;
                    end
                end
                if (ce_fall) begin
                    next_state = RX_ADDR;
                    if (addr_ok && rx_enable) begin
                        if (next_cnt == FRAME_BITS_CNT &&
                            next_sr[F_KIND_LSB+:2] == KIND_DISPLAY) begin
                            next_cfg.segment_data_bits =
                                next_sr[SEG_COUNT-1:0];
                            next_cfg.drive_type_bit0 = next_sr[F_DT0];
                            next_cfg.drive_type_bit1 = next_sr[F_DT1];
                            next_cfg.frame_rate_sel =
                                next_sr[F_FC_LSB+:4];
                            next_cfg.last_segment_enable = next_sr[F_DN];
                            next_cfg.ext_clock_rate_sel = next_sr[F_EXF];
                            next_cfg.clock_source_sel = next_sr[F_OC];
                            next_cfg.all_segments_blank =
                                next_sr[F_SC];
                            next_cfg.low_power_sel = next_sr[F_BU];
                            next_cfg.port_pin_function_sel =
                                next_sr[F_P_LSB+:3];
                            next_good = good_cnt + 16'h0001;
                        end else if (next_cnt == FRAME_BITS_CNT &&
                            next_sr[F_KIND_LSB+:2] == KIND_PULSE) begin
                            next_cfg.pulse_duty_ch1 =
                                next_sr[F_W1_LSB+:DUTY_BITS];
                            next_cfg.pulse_duty_ch2 =
                                next_sr[F_W2_LSB+:DUTY_BITS];
                            next_cfg.pulse_duty_ch3 =
                                next_sr[F_W3_LSB+:DUTY_BITS];
                            next_good = good_cnt + 16'h0001;
                        end else begin
                            next_bad = bad_cnt + 16'h0001;
                        end
                    end
                end
            end
            default: next_state = RX_ADDR;
        endcase
    end

    // Receiver registers; the serial frame is the only writer of cfg
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= RX_ADDR;
            addr_sr <= 8'h00;
            sr <= 48'h000000000000;
            cnt <= 6'h00;
            addr_ok <= 1'b0;
            cfg_q <= '0;
            good_cnt <= 16'h0000;
            bad_cnt <= 16'h0000;
        end else if (clk_en) begin
            state <= next_state;
            addr_sr <= next_addr_sr;
            sr <= next_sr;
            cnt <= next_cnt;
            addr_ok <= next_addr_ok;
            cfg_q <= next_cfg;
            good_cnt <= next_good;
            bad_cnt <= next_bad;
        end
    end

    assign cfg = cfg_q;
    assign ext_rate_effective =
        cfg_q.clock_source_sel & cfg_q.ext_clock_rate_sel;
    assign osc_running = disp_on;

    // Drive type decode, first listed bit (drive_type_bit0) is code bit 1
    always_comb begin
        case ({cfg_q.drive_type_bit0, cfg_q.drive_type_bit1})
            2'h0: mode = DRV_QUARTER;
            2'h2: mode = DRV_THIRD;
            2'h1: mode = DRV_HALF;
            default: mode = DRV_STATIC;
        endcase
        case (mode)
            DRV_QUARTER: duty_last = 2'h3;
            DRV_THIRD: duty_last = 2'h2;
            DRV_HALF: duty_last = 2'h1;
            default: duty_last = 2'h0;
        endcase
    end

    // Half-frame timer; it stands still with the oscillator
    assign half_limit = 20'(HALF_FRAME_CYCLES *
        (int'(cfg_q.frame_rate_sel) + 1) - 1);
    assign half_tick = disp_on && (tmr == half_limit);
    always_comb begin
        next_tmr = tmr;
        next_phase = phase;
        next_slot = slot;
        if (disp_on) begin
            next_tmr = tmr + 20'h00001;
            if (half_tick || tmr > half_limit) begin
                next_tmr = 20'h00000;
                next_phase = ~phase;
                if (phase) begin
                    next_slot = (slot >= duty_last) ? 2'h0 : slot + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr <= 20'h00000;
            phase <= 1'b0;
            slot <= 2'h0;
        end else if (clk_en) begin
            tmr <= next_tmr;
            phase <= next_phase;
            slot <= next_slot;
        end
    end

    // Segment level: equal to common when off, opposite when on
    for (genvar i = 0; i < SEG_COUNT; i++) begin : g_seg
        assign seg_lvl[i] = (cfg_q.segment_data_bits[i] &
            ~cfg_q.all_segments_blank) ^ phase;
    end

    // Pin mux; multiplexed bias levels are left to the analog stage
    // Function code bit 0 is the first listed select bit
    always_comb begin
        case (cfg_q.port_pin_function_sel)
            3'h4: port_mask = 4'h1;
            3'h2: port_mask = 4'h3;
            3'h6: port_mask = 4'h7;
            3'h1: port_mask = 4'hF;
            default: port_mask = 4'h0;
        endcase
        next_pins = '0;
        next_pins.segment_outputs = seg_lvl[23:0];
        next_pins.segment_outputs[3:0] =
            (port_mask & cfg_q.segment_data_bits[3:0]) |
            (~port_mask & seg_lvl[3:0]);
        // Static ignores the slot, which may be stale after a mode change
        next_pins.common_out_1 =
            (mode == DRV_STATIC || slot == 2'h0) & phase;
        next_pins.common2_or_segment = (mode == DRV_STATIC) ?
            seg_lvl[26] : ((slot == 2'h1) & phase);
        next_pins.common3_or_segment =
            (mode == DRV_STATIC || mode == DRV_HALF) ?
            seg_lvl[25] : ((slot == 2'h2) & phase);
        next_pins.common4_or_segment = (mode != DRV_QUARTER) ?
            seg_lvl[24] : ((slot == 2'h3) & phase);
        next_pins.last_segment_out =
            cfg_q.last_segment_enable & seg_lvl[27];
        if (!disp_on) begin
            next_pins = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins <= '0;
        end else if (clk_en) begin
            pins <= next_pins;
        end
    end

    // APB slave, zero wait states; read data latched in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(paddr == REG_CTRL ||
        paddr == REG_STATUS || paddr == REG_GOOD || paddr == REG_BAD);
    always_comb begin
        next_rx_enable = rx_enable;
        next_prdata = prdata;
        if (psel && penable && pwrite && paddr == REG_CTRL) begin
            next_rx_enable = pwdata[0];
        end
        if (psel && !penable && !pwrite) begin
            case (paddr)
                REG_CTRL: next_prdata = {31'h00000000, rx_enable};
                REG_STATUS: next_prdata = {25'h0000000, disp_on,
                    state == RX_DATA, cfg_q.low_power_sel,
                    cfg_q.all_segments_blank, cfg_q.drive_type_bit1,
                    cfg_q.drive_type_bit0, disp_on};
                REG_GOOD: next_prdata = {16'h0000, good_cnt};
                REG_BAD: next_prdata = {16'h0000, bad_cnt};
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_enable <= CTRL_RESET;
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            rx_enable <= next_rx_enable;
            prdata <= next_prdata;
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_bad_end;
        clk_en && state == RX_DATA && ce_fall && next_cnt != FRAME_BITS_CNT;
    endsequence
    sequence s_miss_end;
        clk_en && state == RX_DATA && ce_fall && !addr_ok;
    endsequence

    chk_pins_forced_low: assert property (
        clk_en && !disp_on |=> pins == '0)
        else $error("outputs not low while display off");
    chk_commit_on_fall: assert property (
        !$stable(cfg_q) |-> $past(ce_fall) && $past(state) == RX_DATA)
        else $error("registers changed outside chip enable fall");
    chk_bad_length: assert property (
        s_bad_end |=> $stable(cfg_q) ##0 bad_cnt != $past(bad_cnt) ||
        !$past(addr_ok) || !$past(rx_enable))
        else $error("wrong length frame not discarded");
    chk_addr_miss: assert property (
        s_miss_end |=> $stable(cfg_q) ##1 $stable(cfg_q))
        else $error("frame for other address committed");
    chk_bit_sample: assert property (
        clk_en && state == RX_DATA && cl_rise |=>
        sr[FRAME_BITS-1] == $past(di_s))
        else $error("serial bit not sampled on clock rise");
    chk_static_toggle: assert property (
        clk_en && half_tick |=> phase != $past(phase) ##1
        (mode != DRV_STATIC || !$past(disp_on) ||
         pins.common_out_1 == $past(phase, 1)))
        else $error("common did not alternate at half frame");
    chk_static_segment: assert property (
        clk_en && disp_on && mode == DRV_STATIC &&
        !cfg_q.all_segments_blank && $stable(cfg_q) |=>
        pins.segment_outputs[4] ==
        ($past(cfg_q.segment_data_bits[4]) ^ pins.common_out_1))
        else $error("static segment level wrong");
    chk_last_segment: assert property (
        clk_en && !cfg_q.last_segment_enable |=> !pins.last_segment_out)
        else $error("last segment driven while disabled");
    chk_ext_rate: assert property (
        ext_rate_effective |-> cfg_q.clock_source_sel)
        else $error("external rate active on internal clock");
endmodule // slcr_receiver

// ===== slcr_receiver_bench.sv
module slcr_receiver_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import slcr_pkg::*;

    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic display_off_n, ce, cl, di, ext_rate, osc, en;
    slcr_cfg_t cfg, cur_cfg, seen_cfg;
    slcr_pins_t pins;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    int n_good = 0;
    int n_bad = 0;
    logic [31:0] q_rd[$];
    logic q_err[$];
    slcr_cfg_t q_cfg[$];
    logic [47:0] f;

    always #5 pclk = ~pclk;

    slcr_host_model host (.chip_enable_in(ce), .serial_bit_clock_in(cl),
        .serial_bit_in(di));

    // Short half frame keeps the waveform checks quick
    slcr_receiver #(.HALF_FRAME_CYCLES(4)) uut (.pclk(pclk),
        .presetn(presetn), .clk_en(en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chip_enable_in(ce),
        .serial_bit_clock_in(cl), .serial_bit_in(di),
        .display_off_n(display_off_n), .cfg(cfg), .pins(pins),
        .ext_rate_effective(ext_rate), .osc_running(osc));

    task automatic cmp(input string what, input logic [63:0] e,
                       input logic [63:0] s);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic wrap_up();
        if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under this
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // Results are matched against the oldest note when they appear
    always @(posedge pclk) begin
        slcr_cfg_t e;
        if (psel && penable && pready && !pwrite && q_rd.size() > 0) begin
            cmp("prdata", 64'(q_rd.pop_front()), 64'(prdata));
            cmp("pslverr", 64'(q_err.pop_front()), 64'(pslverr));
        end
        if (cfg !== seen_cfg) begin
            e = (q_cfg.size() > 0) ? q_cfg.pop_front() : seen_cfg;
            cmp("cfg", 64'(e), 64'(cfg));
            seen_cfg = cfg;
        end
    end

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic err);
        if (!w) begin
            q_rd.push_back(d);
            q_err.push_back(err);
        end
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [47:0] rnd(input logic [1:0] kind,
                                        input logic [1:0] dt);
        logic [47:0] r;
        r = 48'({$urandom, $urandom});
        r[F_KIND_LSB +: 2] = kind;
        r[F_DT0] = dt[1];
        r[F_DT1] = dt[0];
        r[F_P_LSB +: 3] = 3'h0;
        return r;
    endfunction

    // Display frames set all but the duty fields; pulse frames only those
    task automatic frame(input logic [7:0] a, input logic [47:0] fr,
                         input int n, input logic idle, input logic good);
        if (good && fr[F_KIND_LSB +: 2] == KIND_PULSE) begin
            {cur_cfg.pulse_duty_ch3, cur_cfg.pulse_duty_ch2,
                cur_cfg.pulse_duty_ch1} = fr[17:0];
        end else if (good) begin
            {cur_cfg.port_pin_function_sel, cur_cfg.low_power_sel,
                cur_cfg.all_segments_blank, cur_cfg.clock_source_sel,
                cur_cfg.ext_clock_rate_sel, cur_cfg.last_segment_enable,
                cur_cfg.frame_rate_sel, cur_cfg.drive_type_bit1,
                cur_cfg.drive_type_bit0, cur_cfg.segment_data_bits} =
                fr[41:0];
        end
        if (good) q_cfg.push_back(cur_cfg);
        n_good += int'(good);
        host.send(a, fr, n, idle);
        repeat (8) @(posedge pclk);
        cmp("ext_rate", 64'(cur_cfg.clock_source_sel &
            cur_cfg.ext_clock_rate_sel), 64'(ext_rate));
    endtask

    task automatic status(input logic on);
        apb(1'b0, REG_STATUS, {25'h0, on, 1'b0, cur_cfg.low_power_sel,
            cur_cfg.all_segments_blank, cur_cfg.drive_type_bit1,
            cur_cfg.drive_type_bit0, on}, 1'b0);
    endtask

    // Static drive: segments follow common, inverted where lit
    task automatic chk_static();
        logic c;
        logic [27:0] s;
        logic [23:0] e24;
        int n;
        s = cur_cfg.segment_data_bits & ~{28{cur_cfg.all_segments_blank}};
        for (int j = 0; j < 6; j++) begin
            @(posedge pclk);
            c = pins.common_out_1;
            e24 = {24{c}} ^ s[23:0];
            // Code 1 turns all four shared pins into plain ports
            if (cur_cfg.port_pin_function_sel == 3'h1) begin
                e24[3:0] = cur_cfg.segment_data_bits[3:0];
            end
            cmp("seg", 64'(e24), 64'(pins.segment_outputs));
            cmp("shared", 64'({3{c}} ^ {s[26], s[25], s[24]}),
                64'({pins.common2_or_segment, pins.common3_or_segment,
                pins.common4_or_segment}));
            cmp("last", 64'(cur_cfg.last_segment_enable & (c ^ s[27])),
                64'(pins.last_segment_out));
        end
        c = pins.common_out_1;
        while (pins.common_out_1 === c) @(posedge pclk);
        c = pins.common_out_1;
        n = 0;
        while (pins.common_out_1 === c) begin
            @(posedge pclk);
            n++;
        end
        cmp("half", 64'(4 * (cur_cfg.frame_rate_sel + 1)), 64'(n));
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        display_off_n = 1'b0;
        en = 1'b1;
        cur_cfg = '0;
        seen_cfg = '0;
        void'($urandom(32'h265CDD1E));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h1, 1'b0);
        status(1'b0);
        apb(1'b1, REG_STATUS, 32'hFFFFFFFF, 1'b0);
        apb(1'b0, 8'h10, 32'h0, 1'b1);
        // Configure while the display is held off, every drive type
        for (int k = 0; k < 4; k++) begin
            frame(DEV_ADDR_DEFAULT, rnd(KIND_DISPLAY, 2'(k)), 48,
                1'(k), 1'b1);
            status(1'b0);
        end
        cmp("pins_off", 64'h0, 64'(pins));
        cmp("osc", 64'h0, 64'(osc));
        // Frames that must leave the configuration as it was, then one good pulse frame
        frame(DEV_ADDR_DEFAULT, rnd(KIND_DISPLAY, 2'h3), 47, 0, 0);
        frame(DEV_ADDR_DEFAULT, rnd(KIND_DISPLAY, 2'h3), 49, 1, 0);
        frame(DEV_ADDR_DEFAULT, rnd(2'h2, 2'h3), 48, 0, 0);
        frame(~DEV_ADDR_DEFAULT, rnd(KIND_DISPLAY, 2'h3), 48, 0, 0);
        apb(1'b1, REG_CTRL, 32'h0, 1'b0);
        frame(DEV_ADDR_DEFAULT, rnd(KIND_DISPLAY, 2'h3), 48, 0, 0);
        apb(1'b1, REG_CTRL, 32'h1, 1'b0);
        frame(DEV_ADDR_DEFAULT, rnd(KIND_PULSE, 2'h0), 48, 1, 1);
        apb(1'b0, REG_GOOD, 32'(n_good), 1'b0);
        apb(1'b0, REG_BAD, 32'h3, 1'b0);
        // Static drive with the display on, lit and then blanked;
        // the blanked pass also turns the shared pins into ports
        display_off_n <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            f = rnd(KIND_DISPLAY, 2'h3);
            f[F_SC] = 1'(k);
            f[F_P_LSB +: 3] = 3'(k);
            frame(DEV_ADDR_DEFAULT, f, 48, 1'(k), 1'b1);
            cmp("osc", 64'h1, 64'(osc));
            status(1'b1);
            chk_static();
        end
        // Clock enable low must freeze the running waveform
        en <= 1'b0;
        repeat (2) @(posedge pclk);
        f = 48'(pins);
        repeat (10) @(posedge pclk);
        cmp("freeze", 64'(f), 64'(pins));
        en <= 1'b1;
        display_off_n <= 1'b0;
        repeat (6) @(posedge pclk);
        cmp("pins_off", 64'h0, 64'(pins));
        cmp("pending", 64'h0, 64'(q_cfg.size()));
        wrap_up();
    end
endmodule // slcr_receiver_bench
